// >>> design/lcc_pkg.sv
// package of constants and types for the lithium cell charge controller
package lcc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int RELAX_MIN_US    = 2000;    // least relax pause after fast-charge timeout
  localparam int RELAX_CYCLES    = (RELAX_MIN_US * (CLK_HZ / 1_000_000));
  localparam int PRECOND_DIVISOR = 3;       // precondition timeout = normal / 3
  localparam int TIMER_W         = 32;
  localparam int TICK_W          = 24;
  localparam logic [TICK_W-1:0]  TICK_DEFAULT = 24'h00C350; // 1 ms at 50 MHz
  localparam logic [TIMER_W-1:0] NORMAL_TICKS_DEFAULT  = 32'h0002BF20;
  localparam logic [TIMER_W-1:0] TOTAL_TICKS_DEFAULT   = 32'h00041EB0;

  // ****************************************************************
  // current selection codes on the regulation loop
  // ****************************************************************
  localparam logic [1:0] ISEL_OFF     = 2'h0;
  localparam logic [1:0] ISEL_PRECOND = 2'h1;  // 10 percent of setting
  localparam logic [1:0] ISEL_FULL    = 2'h2;
  localparam logic [1:0] ISEL_CV      = 2'h3;  // voltage regulation

  typedef enum logic [2:0] {
    PRECOND,
    FASTCHG,
    TOPOFF,
    EOC_RELAX,
    EOC_WAIT,
    SUSPEND,
    FAULT
  } lcc_state_type;

endpackage

// >>> design/lcc_charge_fsm.sv
// charger state machine, input over-voltage handling and status outputs
`timescale 1ns/100ps

module lcc_charge_fsm #(
  parameter int RELAX_CYCLES = lcc_pkg::RELAX_CYCLES
) (
  input  wire logic                      clk,               // 50 MHz clock
  input  wire logic                      resetn,            // async reset, low
  input  wire logic                      inputValid,        // supply present
  input  wire logic                      inputOverVoltage,  // supply above 6.9V
  input  wire logic                      enable,            // high: run
  input  wire logic                      chargeDisableFloat,// pin floating
  input  wire logic                      battAbovePrecond,  // above 2.85V
  input  wire logic                      battAtTerm,        // at termination
  input  wire logic                      battBelowRecharge, // 175mV below term
  input  wire logic                      currBelowEoc10,    // below 10 percent
  input  wire logic                      currBelowEoc4,     // below 4 percent
  input  wire logic                      inputTypeSelect,   // 1: 10 percent
  input  wire logic [lcc_pkg::TICK_W-1:0]  tickCount,       // cycles per tick
  input  wire logic [lcc_pkg::TIMER_W-1:0] normalTicks,     // normal timeout
  input  wire logic [lcc_pkg::TIMER_W-1:0] totalTicks,      // total timeout
  output logic                           inputPassFetOn,    // input FET gate
  output logic                           batterySwitchOn,   // battery FET gate
  output logic                           overvoltageFlagN,  // low on INPUT_OVERVOLTAGE_GUARD
  output logic                           chargeStateOut1N,  // status 1
  output logic                           chargeStateOut2N,  // status 2
  output logic [1:0]                     currentSelect,     // loop setpoint
  output logic                           chargeFault        // fault state
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  // limits that the logic cannot serve are refused at elaboration
  if (RELAX_CYCLES < 1) begin : g_chk
    $error("RELAX_CYCLES must be at least one");
  end
  if (lcc_pkg::PRECOND_DIVISOR < 1) begin : g_chk_div
    $error("precondition divisor must be at least one");
  end
  if (lcc_pkg::TICK_W > lcc_pkg::TIMER_W) begin : g_chk_w
    $error("tick counter may not be wider than the charge timer");
  end

  // ****************************************************************
  // synchronisers for comparator and pin inputs
  // ****************************************************************
  localparam int NSYNC     = 10;
  // bit positions of the flags in the synchroniser bank
  localparam int IDX_VALID = 9;
  localparam int IDX_OVP   = 8;
  localparam int IDX_EN    = 7;
  localparam int IDX_FLOAT = 6;
  localparam int IDX_PRE   = 5;
  localparam int IDX_TERM  = 4;
  localparam int IDX_RECHG = 3;
  localparam int IDX_EOC10 = 2;
  localparam int IDX_EOC4  = 1;
  localparam int IDX_ACSEL = 0;

  if (IDX_VALID != NSYNC - 1) begin : g_chk_sync
    $error("synchroniser bank and flag positions disagree");
  end

  wire  [NSYNC-1:0] rawIn = {inputValid, inputOverVoltage, enable,
                             chargeDisableFloat, battAbovePrecond,
                             battAtTerm, battBelowRecharge, currBelowEoc10,
                             currBelowEoc4, inputTypeSelect};
  wire  [NSYNC-1:0] syncOut;

  // one two-stage synchroniser per flag; logic reads only the second stage,
  // so a metastable first stage never fans out
  // flags reset low: the charger sees no supply and starts suspended
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    logic stageA_reg;
    logic stageB_reg;

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        stageA_reg <= 1'b0;
        stageB_reg <= 1'b0;
      end else begin
        stageA_reg <= rawIn[i];
        stageB_reg <= stageA_reg;
      end
    end

    assign syncOut[i] = stageB_reg;
  end

  // ****************************************************************
  // synchronised flags
  // ****************************************************************
  wire vValid   = syncOut[IDX_VALID];
  wire vOvp     = syncOut[IDX_OVP];
  wire vEnable  = syncOut[IDX_EN];
  wire vDisFlt  = syncOut[IDX_FLOAT];
  wire vPre     = syncOut[IDX_PRE];
  wire termination_voltage    = syncOut[IDX_TERM];
  wire vRechg   = syncOut[IDX_RECHG];
  wire vEoc10   = syncOut[IDX_EOC10];
  wire vEoc4    = syncOut[IDX_EOC4];
  wire vAcSel   = syncOut[IDX_ACSEL];

  // ****************************************************************
  // tick generator and charge timer
  // ****************************************************************
  logic [lcc_pkg::TICK_W-1:0]  tickCnt_reg;
  logic [lcc_pkg::TIMER_W-1:0] timer_reg;
  logic [lcc_pkg::TIMER_W-1:0] timer_next;
  logic [31:0]                 relax_reg;
  logic                        validPrev_reg;
  lcc_pkg::lcc_state_type      state_reg;
  lcc_pkg::lcc_state_type      state_next;

  wire tickHit = (tickCnt_reg + 1'b1 >= tickCount);
  wire [lcc_pkg::TICK_W-1:0] tickCnt_next =
    tickHit ? '0 : tickCnt_reg + 1'b1;
  // every cause that holds the charger in suspend
  wire offByEnable = !vEnable;
  wire offByFloat  = vDisFlt;
  wire offBySupply = !vValid || vOvp;
  wire chargerOff  = offByEnable || offByFloat || offBySupply;
  // input lost and back restarts a cycle, even from fault
  wire inputReturn = vValid && !validPrev_reg;
  // integer divide: a normal limit below three faults precondition at once
  wire [lcc_pkg::TIMER_W-1:0] precondTicks =
    normalTicks / lcc_pkg::TIMER_W'(lcc_pkg::PRECOND_DIVISOR);
  wire eocCurrent = vAcSel ? vEoc10 : vEoc4;
  wire stateChange = (state_next != state_reg);
  wire timerFull = (timer_reg == '1);

  // ****************************************************************
  // transition conditions
  // ****************************************************************
  wire precondExpired = (timer_reg >= precondTicks);
  wire fastExpired    = (timer_reg >= normalTicks);
  wire topExpired     = (timer_reg >= totalTicks);
  wire relaxDone      = (relax_reg >= 32'(RELAX_CYCLES - 1));
  wire inRelax        = (state_reg == lcc_pkg::EOC_RELAX);
  wire [31:0] relax_next = (inRelax && !stateChange) ? relax_reg + 1'b1 : '0;

  always_comb begin
    timer_next = timer_reg;
    if (stateChange) begin
      timer_next = '0;
    end else if (tickHit && !timerFull) begin
      // saturate: a long wait in end of charge must never wrap to zero
      timer_next = timer_reg + 1'b1;
    end
  end

  // ****************************************************************
  // tick prescaler and charge timer registers
  // ****************************************************************
  // a tickCount of zero or one ticks every cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tickCnt_reg <= '0;
    end else begin
      tickCnt_reg <= tickCnt_next;
    end
  end

  // the one timer serves all three limits; it restarts on each state change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_next;
    end
  end

  // ****************************************************************
  // charger state machine
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lcc_pkg::PRECOND: begin
        if (vPre) begin
          state_next = lcc_pkg::FASTCHG;
        end else if (precondExpired) begin
          state_next = lcc_pkg::FAULT;
        end
      end
      lcc_pkg::FASTCHG: begin
        if (termination_voltage) begin
          state_next = lcc_pkg::TOPOFF;
        end else if (fastExpired) begin
          state_next = lcc_pkg::EOC_RELAX;
        end
      end
      lcc_pkg::TOPOFF: begin
        if (eocCurrent) begin
          state_next = lcc_pkg::EOC_WAIT;
        end else if (topExpired) begin
          state_next = lcc_pkg::EOC_WAIT;
        end
      end
      lcc_pkg::EOC_RELAX: begin
        if (relaxDone) begin
          state_next = lcc_pkg::PRECOND;
        end
      end
      lcc_pkg::EOC_WAIT: begin
        if (vRechg) begin
          state_next = lcc_pkg::PRECOND;
        end
      end
      lcc_pkg::SUSPEND: begin
        if (!chargerOff) begin
          state_next = lcc_pkg::PRECOND;
        end
      end
      lcc_pkg::FAULT: begin
        if (inputReturn) begin
          state_next = lcc_pkg::PRECOND;
        end
      end
      default: state_next = lcc_pkg::SUSPEND;
    endcase
    // suspend overrides every state, fault included, so exit restarts
    if (chargerOff) begin
      state_next = lcc_pkg::SUSPEND;
    end
  end

  // ****************************************************************
  // state register, supply edge detector and relax counter
  // ****************************************************************

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= lcc_pkg::SUSPEND;
    end else begin
      state_reg <= state_next;
    end
  end

  // starts low like the synchronised flag, so reset makes no false edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      validPrev_reg <= 1'b0;
    end else begin
      validPrev_reg <= vValid;
    end
  end

  // relax pause counter, runs only in the post-timeout relax state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      relax_reg <= '0;
    end else begin
      relax_reg <= relax_next;
    end
  end

  // ****************************************************************
  // outputs, all registered
  // ****************************************************************
  // current setpoint handed to the regulation loop for each state
  function automatic logic [1:0] iselFor(input lcc_pkg::lcc_state_type s);
    case (s)
      lcc_pkg::PRECOND: iselFor = lcc_pkg::ISEL_PRECOND;
      lcc_pkg::FASTCHG: iselFor = lcc_pkg::ISEL_FULL;
      lcc_pkg::TOPOFF:  iselFor = lcc_pkg::ISEL_CV;
      default:          iselFor = lcc_pkg::ISEL_OFF;
    endcase
  endfunction

  // status pair {out1, out2}, both active low
  function automatic logic [1:0] statusFor(input lcc_pkg::lcc_state_type s);
    case (s)
      lcc_pkg::PRECOND: statusFor = 2'h0;
      lcc_pkg::FASTCHG: statusFor = 2'h1;
      default:          statusFor = 2'h3;
    endcase
  endfunction

  wire [1:0] iselNext   = iselFor(state_next);
  wire [1:0] statusNext = statusFor(state_next);
  wire       faultNext  = (state_next == lcc_pkg::FAULT);
  // the input FET is on whenever enabled on a sound supply, in any state, fault included
  wire suspendedIn = !vEnable && vValid;
  wire passOn = vValid && !vOvp && !suspendedIn;

  // ****************************************************************
  // output registers
  // ****************************************************************
  // power path; reset leaves the system on the battery
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inputPassFetOn   <= 1'b0;
      batterySwitchOn  <= 1'b1;
      overvoltageFlagN <= 1'b1;
    end else begin
      inputPassFetOn   <= passOn;
      batterySwitchOn  <= !passOn;
      overvoltageFlagN <= !vOvp;
    end
  end

  // status pins and setpoint follow the next state, so they change
  // on the same edge as the state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chargeStateOut1N <= 1'b1;
      chargeStateOut2N <= 1'b1;
      currentSelect    <= lcc_pkg::ISEL_OFF;
      chargeFault      <= 1'b0;
    end else begin
      chargeStateOut1N <= statusNext[1];
      chargeStateOut2N <= statusNext[0];
      currentSelect    <= iselNext;
      chargeFault      <= faultNext;
    end
  end

endmodule

// >>> testbench/lcc_cell_model.sv
// battery cell and input supply model driving the comparator flags
`timescale 1ns/100ps
module lcc_cell_model #(
  parameter logic [15:0] UVLO_MV = 16'h0FA0,  // plain default, not documented
  parameter logic [15:0] TERM_MV = 16'h1068
) (
  input  wire logic [15:0] supplyMv,          // supply voltage, mV
  input  wire logic [15:0] battMv,            // cell voltage, mV
  input  wire logic [7:0]  currPct,           // current, percent of setting
  output logic             inputValid,        // supply above lockout
  output logic             inputOverVoltage,  // supply above limit
  output logic             battAbovePrecond,  // cell above precharge level
  output logic             battAtTerm,        // cell at termination
  output logic             battBelowRecharge, // cell well below termination
  output logic             currBelowEoc10,    // current under 10 percent
  output logic             currBelowEoc4      // current under 4 percent
);
  assign inputValid = supplyMv > UVLO_MV;
  assign inputOverVoltage = supplyMv > 16'h1AF4;
  assign battAbovePrecond = battMv > 16'h0B22;
  assign battAtTerm = battMv >= TERM_MV;
  assign battBelowRecharge = battMv <= (TERM_MV - 16'h00AF);
  assign currBelowEoc10 = currPct < 8'h0A;
  assign currBelowEoc4 = currPct < 8'h04;
endmodule

// >>> testbench/lcc_fsm_sva.sv
// port checker for the charger state machine
`timescale 1ns/100ps
module lcc_fsm_sva (
  input wire logic       clk,                // clock
  input wire logic       resetn,             // reset, low
  input wire logic       inputValid,         // supply present
  input wire logic       inputOverVoltage,   // supply too high
  input wire logic       enable,             // run
  input wire logic       chargeDisableFloat, // disable pin floating
  input wire logic       battAbovePrecond,   // above precharge level
  input wire logic       inputPassFetOn,     // input FET
  input wire logic       batterySwitchOn,    // battery FET
  input wire logic       overvoltageFlagN,   // over-voltage flag
  input wire logic       chargeStateOut1N,   // status 1
  input wire logic       chargeStateOut2N,   // status 2
  input wire logic [1:0] currentSelect,      // setpoint
  input wire logic       chargeFault         // fault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // inputs need four samples: two synchroniser stages, one state edge
  sequence runOk;
    enable && inputValid && !inputOverVoltage && !chargeDisableFloat;
  endsequence
  sequence inPre;
    currentSelect == lcc_pkg::ISEL_PRECOND;
  endsequence
  chk_ovp_flag_low: assert property (
    inputOverVoltage[*4] |-> !overvoltageFlagN) else $error("flag not low");
  chk_ovp_flag_free: assert property (
    (!inputOverVoltage)[*4] |-> overvoltageFlagN) else $error("flag stuck");
  chk_ovp_fet_off: assert property (
    inputOverVoltage[*4] |-> !inputPassFetOn && batterySwitchOn)
    else $error("input FET on during over-voltage");
  chk_fet_pair: assert property (
    batterySwitchOn == !inputPassFetOn) else $error("FET pair clash");
  chk_suspend_off: assert property (
    (!enable)[*4] |-> !inputPassFetOn && currentSelect == lcc_pkg::ISEL_OFF)
    else $error("charging while suspended");
  chk_float_off: assert property (
    chargeDisableFloat[*4] |-> currentSelect == lcc_pkg::ISEL_OFF)
    else $error("charging with floating disable pin");
  chk_exit_to_pre: assert property (
    (!enable)[*4] ##1 runOk[*4] |-> inPre) else $error("no precharge");
  chk_pre_to_fast: assert property (
    (currentSelect == lcc_pkg::ISEL_PRECOND && battAbovePrecond)[*3]
    |=> currentSelect != lcc_pkg::ISEL_PRECOND) else $error("stuck in pre");
  chk_pre_status: assert property (
    inPre |-> !chargeStateOut1N && !chargeStateOut2N)
    else $error("precharge status");
  chk_fast_status: assert property (
    currentSelect == lcc_pkg::ISEL_FULL |-> !chargeStateOut1N
    && chargeStateOut2N) else $error("fast status");
  chk_fault_status: assert property (
    chargeFault |-> chargeStateOut1N && chargeStateOut2N
    && currentSelect == lcc_pkg::ISEL_OFF) else $error("fault status");
endmodule

bind lcc_charge_fsm lcc_fsm_sva u_lcc_fsm_sva (.clk(clk), .resetn(resetn),
  .inputValid(inputValid), .inputOverVoltage(inputOverVoltage),
  .enable(enable), .chargeDisableFloat(chargeDisableFloat),
  .battAbovePrecond(battAbovePrecond), .inputPassFetOn(inputPassFetOn),
  .batterySwitchOn(batterySwitchOn), .overvoltageFlagN(overvoltageFlagN),
  .chargeStateOut1N(chargeStateOut1N), .chargeStateOut2N(chargeStateOut2N),
  .currentSelect(currentSelect), .chargeFault(chargeFault));

// >>> testbench/tb.sv
// self-checking testbench for the charger state machine
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        enable = 1'b0;
  logic        chargeDisableFloat = 1'b0;
  logic        inputTypeSelect = 1'b1;
  logic [15:0] supplyMv = 16'h1388;
  logic [15:0] battMv = 16'h07D0;
  logic [7:0]  currPct = 8'h64;
  logic        inputValid, inputOverVoltage, battAbovePrecond, battAtTerm;
  logic        battBelowRecharge, currBelowEoc10, currBelowEoc4;
  logic        inputPassFetOn, batterySwitchOn, overvoltageFlagN;
  logic        chargeStateOut1N, chargeStateOut2N, chargeFault;
  logic [1:0]  currentSelect;
  int          fail_count = 0;
  int          total_checks = 0;
  always #10 clk = ~clk;
  // short relax and tick limits keep the timeouts within a few cycles
  lcc_charge_fsm #(.RELAX_CYCLES(4)) u_lcc_charge_fsm (.clk(clk),
    .resetn(resetn), .inputValid(inputValid),
    .inputOverVoltage(inputOverVoltage), .enable(enable),
    .chargeDisableFloat(chargeDisableFloat),
    .battAbovePrecond(battAbovePrecond), .battAtTerm(battAtTerm),
    .battBelowRecharge(battBelowRecharge), .currBelowEoc10(currBelowEoc10),
    .currBelowEoc4(currBelowEoc4), .inputTypeSelect(inputTypeSelect),
    .tickCount(24'h000001), .normalTicks(32'h0000000C),
    .totalTicks(32'h00000014), .inputPassFetOn(inputPassFetOn),
    .batterySwitchOn(batterySwitchOn), .overvoltageFlagN(overvoltageFlagN),
    .chargeStateOut1N(chargeStateOut1N), .chargeStateOut2N(chargeStateOut2N),
    .currentSelect(currentSelect), .chargeFault(chargeFault));
  lcc_cell_model u_lcc_cell_model (.supplyMv(supplyMv), .battMv(battMv),
    .currPct(currPct), .inputValid(inputValid),
    .inputOverVoltage(inputOverVoltage), .battAbovePrecond(battAbovePrecond),
    .battAtTerm(battAtTerm), .battBelowRecharge(battBelowRecharge),
    .currBelowEoc10(currBelowEoc10), .currBelowEoc4(currBelowEoc4));
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // bounded wait; a timeout shows up as a select mismatch
  task automatic wait_sel(input logic [1:0] exp, input int limit);
    int n;
    n = 0;
    while (currentSelect !== exp && n < limit) begin
      @(negedge clk);
      n++;
    end
    check("currentSelect", {6'h00, currentSelect}, {6'h00, exp});
  endtask
  // order: input FET, battery FET, flag, status 1, status 2, fault
  task automatic outs(input logic [5:0] exp);
    check("outputs", {2'h0, inputPassFetOn, batterySwitchOn,
      overvoltageFlagN, chargeStateOut1N, chargeStateOut2N, chargeFault},
      {2'h0, exp});
  endtask
  task automatic drive(input logic [15:0] mv, input logic [7:0] pct);
    @(negedge clk);
    battMv = mv;
    currPct = pct;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (16) @(negedge clk);
    outs(6'h1E);
    resetn = 1'b1;
    enable = 1'b1;
    wait_sel(lcc_pkg::ISEL_PRECOND, 8);
    outs(6'h28);
    drive(16'h0E74, 8'h64);
    wait_sel(lcc_pkg::ISEL_FULL, 6);
    outs(6'h2A);
    drive(16'h1068, 8'h64);
    wait_sel(lcc_pkg::ISEL_CV, 6);
    outs(6'h2E);
    $display("test charge phases done");
    inputTypeSelect = 1'b0;
    drive(16'h1068, 8'h07);
    repeat (6) @(negedge clk);
    check("currentSelect", {6'h00, currentSelect}, 8'h03);
    inputTypeSelect = 1'b1;
    wait_sel(lcc_pkg::ISEL_OFF, 6);
    drive(16'h0FA0, 8'h64);
    wait_sel(lcc_pkg::ISEL_FULL, 12);
    $display("test end of charge done");
    wait_sel(lcc_pkg::ISEL_OFF, 20);
    repeat (2) @(negedge clk);
    check("currentSelect", {6'h00, currentSelect}, 8'h00);
    wait_sel(lcc_pkg::ISEL_FULL, 12);
    drive(16'h1068, 8'h64);
    wait_sel(lcc_pkg::ISEL_CV, 6);
    wait_sel(lcc_pkg::ISEL_OFF, 30);
    repeat (10) @(negedge clk);
    check("currentSelect", {6'h00, currentSelect}, 8'h00);
    $display("test timeouts done");
    enable = 1'b0;
    repeat (6) @(negedge clk);
    outs(6'h1E);
    drive(16'h07D0, 8'h64);
    enable = 1'b1;
    wait_sel(lcc_pkg::ISEL_PRECOND, 8);
    wait_sel(lcc_pkg::ISEL_OFF, 8);
    outs(6'h2F);
    drive(16'h0E74, 8'h64);
    repeat (8) @(negedge clk);
    outs(6'h2F);
    supplyMv = 16'h0000;
    repeat (6) @(negedge clk);
    supplyMv = 16'h1388;
    wait_sel(lcc_pkg::ISEL_FULL, 12);
    $display("test suspend and fault done");
    supplyMv = 16'h1D4C;
    repeat (5) @(negedge clk);
    outs(6'h16);
    supplyMv = 16'h1388;
    repeat (5) @(negedge clk);
    check("overvoltageFlagN", {7'h00, overvoltageFlagN}, 8'h01);
    chargeDisableFloat = 1'b1;
    wait_sel(lcc_pkg::ISEL_OFF, 6);
    repeat (4) @(negedge clk);
    chargeDisableFloat = 1'b0;
    wait_sel(lcc_pkg::ISEL_FULL, 12);
    $display("test protection done");
    give_verdict();
  end
  initial begin
    #40000;
    fail_count++;
    give_verdict();
  end
endmodule
